//--- core/flash_access_mode_control.sv
// flash access-mode control: size field, access gating, command launch
`timescale 1ns/1ps
`include "flash_mode_cfg.svh"
module flash_access_mode_control #(
  parameter int OP_CYCLES = `OP_CYCLES_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_size_we,
  input wire logic [1:0] i_size_wdata,
  output logic [1:0] o_size,
  output logic o_rom_mode,
  output logic o_prog_mode,
  input wire logic i_rd,
  input wire logic i_rd_word,
  input wire logic i_fetch,
  input wire logic [31:0] i_array_rdata,
  output logic [31:0] o_rdata,
  output logic o_rvalid,
  output logic o_err,
  input wire logic i_cmd_we,
  input wire logic [1:0] i_cmd,
  output logic o_busy,
  output logic o_done,
  output logic [1:0] o_op
);
  // ************************************************
  // access size field
  // ************************************************
  logic [1:0] size_q;
  logic rom_mode;
  logic prog_mode;
  logic [31:0] rdata_q;
  logic rvalid_q;
  logic err_q;
  logic start;

  // one decode shared by both modes, so the two can never disagree on width
  function automatic logic mode_is(input logic [1:0] field, input logic [1:0] code);
    mode_is = (field == code);
  endfunction

  // reset always lands in read-only mode; any written value is kept verbatim
  // values 00 and 11 select neither mode: every access is refused then
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      size_q <= `SIZE_RESET;
    end else if (i_ce && i_size_we) begin
      size_q <= i_size_wdata;
    end
  end

  // mode flags are plain decodes of the stored field
  assign rom_mode = mode_is(size_q, `SIZE_ROM);
  assign prog_mode = mode_is(size_q, `SIZE_PROG);
  assign o_size = size_q;
  assign o_rom_mode = rom_mode;
  assign o_prog_mode = prog_mode;

  // ************************************************
  // read path
  // ************************************************
  // word reads and fetches only in read-only mode; half-words in programming mode
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q <= 32'h0000_0000;
      rvalid_q <= 1'b0;
      err_q <= 1'b0;
    end else if (i_ce) begin
      rvalid_q <= 1'b0;
      err_q <= 1'b0;
      if (i_rd || i_fetch) begin
        if (rom_mode) begin
          rdata_q <= i_array_rdata;
          rvalid_q <= 1'b1;
        end else if (prog_mode && i_rd && !i_rd_word && !i_fetch) begin
          rdata_q <= {16'h0000, i_array_rdata[15:0]};
          rvalid_q <= 1'b1;
        end else begin
          err_q <= 1'b1;
        end
      end
    end
  end

  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;
  assign o_err = err_q;

  // ************************************************
  // command launch
  // ************************************************
  // commands outside programming mode are dropped silently
  assign start = i_cmd_we && prog_mode && (i_cmd != 2'h0);

  flash_algo_seq #(
    .OP_CYCLES(OP_CYCLES)
  ) u_seq (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_start(start),
    .i_cmd(i_cmd),
    .o_busy(o_busy),
    .o_done(o_done),
    .o_op(o_op)
  );

  // ************************************************
  // checks
  // ************************************************
  // busy cycles counted here so the run length can be checked against the
  // parameter without a long repetition in a property
  logic [15:0] busy_cnt_q;

  // cleared at each accepted launch, counts while the sequencer is busy
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_cnt_q <= 16'h0000;
    end else if (i_ce) begin
      if (start && !o_busy && !o_done) begin
        busy_cnt_q <= 16'h0000;
      end else if (o_busy) begin
        busy_cnt_q <= busy_cnt_q + 16'h0001;
      end
    end
  end

  // steps of one command: launch, run, finish
  sequence s_launch;
    i_ce && start && !o_busy && !o_done;
  endsequence

  sequence s_run;
    o_busy;
  endsequence

  // a reset taken while busy also drops busy, so that edge is left out
  sequence s_finish;
    $fell(o_busy) && !$past(i_rst);
  endsequence

  // field and flags come back in read-only state after any reset
  a_reset_rom_mode: assert property (@(posedge i_clk)
    $fell(i_rst) |-> size_q == `SIZE_RESET && rom_mode && !prog_mode)
    else $error("size not 10 after reset");

  // nothing left running or pending once reset is released
  a_reset_idle: assert property (@(posedge i_clk)
    $fell(i_rst) |-> !o_busy && !o_done && !rvalid_q && !err_q)
    else $error("state left over after reset");

  // read-only mode never launches the sequencer
  a_rom_no_start: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && i_cmd_we && !prog_mode && !o_busy) |=> !o_busy)
    else $error("command in rom mode");

  // the launch strobe itself stays low in read-only mode
  a_rom_no_launch: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cmd_we && rom_mode) |-> !start)
    else $error("launch in rom mode");

  // an accepted command starts the algorithm at the next edge
  a_prog_start: assert property (@(posedge i_clk) disable iff (i_rst)
    s_launch |=> s_run)
    else $error("command not started");

  // the operation code is latched with the launch
  a_op_kept: assert property (@(posedge i_clk) disable iff (i_rst)
    s_launch |=> o_op == $past(i_cmd))
    else $error("op not latched");

  // the run lasts exactly the configured number of enabled cycles
  a_busy_length: assert property (@(posedge i_clk) disable iff (i_rst)
    o_done |-> busy_cnt_q == 16'(OP_CYCLES))
    else $error("run length wrong");

  // the end of a run not cut short by reset is marked by the done pulse
  a_done_after_busy: assert property (@(posedge i_clk) disable iff (i_rst)
    s_finish |-> o_done)
    else $error("run ended without done");

  // read-only mode serves the whole word
  a_word_read: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && i_rd && rom_mode) |=> rvalid_q && rdata_q == $past(i_array_rdata))
    else $error("word read wrong");

  // fetch is served in read-only mode
  a_fetch_rom: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && i_fetch && rom_mode) |=> rvalid_q && !err_q)
    else $error("fetch refused in rom mode");

  // half-word reads in programming mode carry the low 16 bits only
  a_half_read: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && i_rd && !i_rd_word && !i_fetch && prog_mode) |=>
    rvalid_q && rdata_q == {16'h0000, $past(i_array_rdata[15:0])})
    else $error("half read wrong");

  // word reads and fetches are refused in programming mode
  a_no_word_prog: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && (i_fetch || (i_rd && i_rd_word)) && prog_mode) |=> err_q && !rvalid_q)
    else $error("word in prog");

  // the field reads back what was written
  a_size_readback: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && i_size_we) |=> o_size == $past(i_size_wdata))
    else $error("size readback");

  // writing 01 enters programming mode and leaves read-only mode
  a_prog_mode: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && i_size_we && i_size_wdata == `SIZE_PROG) |=> o_prog_mode && !o_rom_mode)
    else $error("mode decode");

  // a low enable holds the field and the read data
  a_ce_freeze: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_ce |=> $stable(size_q) && $stable(rdata_q))
    else $error("state moved while frozen");
endmodule // flash_access_mode_control

//--- core/flash_mode_cfg.svh
// constants for the flash access-mode control block
// Notes on behaviour
// - size 10 gives read-only 32-bit words, fetch allowed
// - read-only mode ignores commands, never programs or erases
// - reset forces size field to 10
// - size 01 gives 16-bit programming mode
// - programming mode refuses word access and fetch
// - programming reads return 16-bit half-words
// - programming-mode command writes with a nonzero code start the algorithm when it is idle
// - chip erase, sector erase, half-word programming supported
`ifndef FLASH_MODE_CFG_SVH
`define FLASH_MODE_CFG_SVH
`define SIZE_ROM 2'h2
`define SIZE_PROG 2'h1
`define SIZE_RESET 2'h2
`define CMD_PROGRAM 2'h1
`define CMD_CHIP_ERASE 2'h2
`define CMD_SECTOR_ERASE 2'h3
`define OP_CYCLES_DEF 8
`endif

//--- core/flash_mode_pkg.sv
// types for the flash access-mode control block
package flash_mode_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_BUSY = 2'h1,
    ST_DONE = 2'h3
  } algo_state_t;
endpackage

//--- core/flash_algo_seq.sv
// embedded write/erase sequencer started by accepted commands
`timescale 1ns/1ps
`include "flash_mode_cfg.svh"
module flash_algo_seq #(
  parameter int OP_CYCLES = `OP_CYCLES_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic [1:0] i_cmd,
  output logic o_busy,
  output logic o_done,
  output logic [1:0] o_op
);
  flash_mode_pkg::algo_state_t state_q;
  logic [15:0] cnt_q;
  logic [1:0] op_q;

  // simple timed operation; a start while busy is ignored
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= flash_mode_pkg::ST_IDLE;
      cnt_q <= 16'h0000;
      op_q <= 2'h0;
    end else if (i_ce) begin
      case (state_q)
        flash_mode_pkg::ST_IDLE: begin
          if (i_start) begin
            state_q <= flash_mode_pkg::ST_BUSY;
            op_q <= i_cmd;
            cnt_q <= 16'(OP_CYCLES - 1);
          end
        end
        flash_mode_pkg::ST_BUSY: begin
          if (cnt_q == 16'h0000) begin
            state_q <= flash_mode_pkg::ST_DONE;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        flash_mode_pkg::ST_DONE: begin
          state_q <= flash_mode_pkg::ST_IDLE;
        end
        default: begin
          state_q <= flash_mode_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign o_busy = (state_q == flash_mode_pkg::ST_BUSY);
  assign o_done = (state_q == flash_mode_pkg::ST_DONE);
  assign o_op = op_q;
endmodule // flash_algo_seq

//--- test/flash_cpu_model.sv
// cpu-side request model for the flash access-mode control block
`timescale 1ns/1ps
module flash_cpu_model (
  input wire logic i_clk,
  output logic o_size_we,
  output logic [1:0] o_size_wdata,
  output logic o_rd,
  output logic o_rd_word,
  output logic o_fetch,
  output logic o_cmd_we,
  output logic [1:0] o_cmd,
  output logic [31:0] o_array_rdata
);
  // idle at time zero so nothing is taken during reset
  initial begin
    {o_size_we, o_size_wdata, o_rd, o_rd_word, o_fetch, o_cmd_we, o_cmd, o_array_rdata} = '0;
  end
  // kind 0 size write, 1 word read, 2 half read, 3 fetch, 4 command
  // fetches go out only when the bench asks, refusals included
  task automatic put(input int kind, input logic [1:0] v, input logic [31:0] d);
    @(posedge i_clk);
    o_size_we <= kind == 0;
    o_rd <= kind == 1 || kind == 2;
    o_rd_word <= kind == 1;
    o_fetch <= kind == 3;
    o_cmd_we <= kind == 4;
    o_size_wdata <= v;
    o_cmd <= v;
    o_array_rdata <= d;
    @(posedge i_clk);
    {o_size_we, o_rd, o_fetch, o_cmd_we} <= '0;
    o_array_rdata <= ~d; // released bus shows no stale data
    #1;
  endtask
endmodule // flash_cpu_model

//--- test/flash_access_mode_control_tb.sv
// self-checking bench for the flash access-mode control block
`timescale 1ns/1ps
`define chk(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module flash_access_mode_control_tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic awe, rd, rw, fe, cwe, rv, er, rom, prg, busy, done;
  logic [1:0] awd, cmd, size_v, op;
  logic ce = 1'b1;
  localparam int OPC = 2;
  int k = 0;
  logic [31:0] ad, rdata, d;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 32'h82207335;
  // ***************
  // harness
  // ***************
  initial forever #5 i_clk = ~i_clk;
  flash_cpu_model cpu (.i_clk(i_clk), .o_size_we(awe), .o_size_wdata(awd), .o_rd(rd),
    .o_rd_word(rw), .o_fetch(fe), .o_cmd_we(cwe), .o_cmd(cmd), .o_array_rdata(ad));
  flash_access_mode_control #(.OP_CYCLES(OPC)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
    .i_size_we(awe), .i_size_wdata(awd), .o_size(size_v), .o_rom_mode(rom), .o_prog_mode(prg),
    .i_rd(rd), .i_rd_word(rw), .i_fetch(fe), .i_array_rdata(ad), .o_rdata(rdata),
    .o_rvalid(rv), .o_err(er), .i_cmd_we(cwe), .i_cmd(cmd), .o_busy(busy), .o_done(done),
    .o_op(op));
  // timeout guard; the run needs well under a hundred cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one read of a kind; served data follows the current mode width
  task automatic rd_chk(input int kind, input logic ok, input logic half);
    d = $random(seed);
    cpu.put(kind, 2'h0, d);
    `chk({rv, er}, {ok, !ok})
    if (ok) `chk(rdata, (half ? {16'h0, d[15:0]} : d))
  endtask
  // ***************
  // scenarios
  // ***************
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    `chk({size_v, rom, prg}, {2'h2, 2'b10})
    repeat (4) rd_chk(1, 1'b1, 1'b0);
    rd_chk(3, 1'b1, 1'b0);
    cpu.put(4, 2'h1, 32'h0);
    `chk(busy, 1'b0)
    cpu.put(0, 2'h1, 32'h0);
    `chk({size_v, rom, prg}, {2'h1, 2'b01})
    repeat (4) rd_chk(2, 1'b1, 1'b1);
    rd_chk(1, 1'b0, 1'b1);
    rd_chk(3, 1'b0, 1'b1);
    // a frozen block must ignore a size write
    @(posedge i_clk) ce <= 1'b0;
    cpu.put(0, 2'h3, 32'h0);
    `chk(size_v, 2'h1)
    @(posedge i_clk) ce <= 1'b1;
    for (int c = 1; c < 4; c++) begin
      cpu.put(4, c[1:0], 32'h0);
      `chk({busy, op}, {1'b1, c[1:0]})
      for (k = 0; k < 20 && done !== 1'b1; k++) @(posedge i_clk) #1;
      `chk(done, 1'b1)
      `chk(k, OPC)
    end
    cpu.put(0, 2'h3, 32'h0);
    `chk({size_v, rom, prg}, {2'h3, 2'b00})
    rd_chk(2, 1'b0, 1'b0);
    // reset taken in programming mode with a command running
    cpu.put(0, 2'h1, 32'h0);
    cpu.put(4, 2'h2, 32'h0);
    `chk(busy, 1'b1)
    i_rst <= 1'b1;
    @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    `chk({size_v, rom, busy}, {2'h2, 2'b10})
    rd_chk(1, 1'b1, 1'b0);
    tally_and_finish();
  end
endmodule // flash_access_mode_control_tb
